//--- verilog/lane_cfg_pkg.sv
package lane_cfg_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_MODE = 10'h004;
   localparam logic [9:0] IDX_PAT_HPF = 10'h039;
   localparam logic [9:0] IDX_PAT_B = 10'h03B;
   localparam logic [11:0] ADDR_MODE = {IDX_MODE, 2'b00};
   localparam logic [11:0] ADDR_PAT_HPF = {IDX_PAT_HPF, 2'b00};
   localparam logic [11:0] ADDR_PAT_B = {IDX_PAT_B, 2'b00};
   // field positions, first register
   localparam int PRBS13_POS = 15;
   localparam int PRBS14_POS = 14;
   localparam int PRBS15_POS = 13;
   localparam int PRBS16_POS = 12;
   localparam int CODE13_LSB = 9;
   localparam int CODE14_LSB = 6;
   localparam int HPF_K_LSB = 1;
   localparam int HPF_EN_POS = 0;
   // field positions, second register and mode register
   localparam int CODE15_LSB = 5;
   localparam int CODE16_LSB = 2;
   localparam int IND_SEL_POS = 8;
   // writable bits; reserved bits hold zero
   localparam logic [15:0] MASK_PAT_HPF = 16'hFFDF;
   localparam logic [15:0] MASK_PAT_B = 16'h00FC;
   localparam logic [15:0] MASK_MODE = 16'h0100;
   // reset values
   localparam logic [15:0] RST_PAT_HPF = 16'h0000;
   localparam logic [15:0] RST_PAT_B = 16'h0000;
   localparam logic RST_IND_SEL = 1'b0;
   // sample path
   localparam int SAMPLE_W = 14;
   localparam int OUT_W = 16;
   localparam int SUM_W = 18;
   localparam int PROD_W = 36;
   localparam logic signed [35:0] OUT_MAX = 36'sh0_0000_7FFF;
   localparam logic signed [35:0] OUT_MIN = -36'sh0_0000_8000;
endpackage : lane_cfg_pkg

//--- verilog/lane_pattern_hpf_config.sv
// Operation
// - lane 13-16 pseudo-random enables at bits 15-12, active only with independent select
// - bits 11-9 of first register select lane 13 test code
// - bits 8-6 of first register select lane 14 test code
// - bits 7-5 of second register select lane 15 test code
// - bits 4-2 of second register select lane 16 test code
// - bit 0 of first register enables the filter; zero bypasses
// - bits 4-1 of first register hold filter parameter k
// - filter output is 2^k/(2^k+1) times (x - previous x + previous y)
// - second register answers at address 3Bh
// - first register answers at address 39h
`timescale 1ns/1ps
`default_nettype none

module lane_pattern_hpf_config (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sampleValid,
   input wire logic [1:0] sampleChan,
   input wire logic [13:0] sampleIn,
   output logic sampleOutValid,
   output logic [1:0] sampleOutChan,
   output logic [15:0] sampleOut,
   output logic independentPatternSelect,
   output logic pseudoRandomEnLane13,
   output logic pseudoRandomEnLane14,
   output logic pseudoRandomEnLane15,
   output logic pseudoRandomEnLane16,
   output logic [2:0] testCodeLane13,
   output logic [2:0] testCodeLane14,
   output logic [2:0] testCodeLane15,
   output logic [2:0] testCodeLane16,
   output logic highpassEnableUpperGroup,
   output logic [3:0] highpassKUpperGroup
);

   typedef struct packed {
      logic [15:0] patHpf;
      logic [15:0] patB;
      logic indSel;
      logic ready;
      logic slvErr;
      logic [31:0] rdata;
      logic [3:0] prbsOut;
      logic [11:0] codeOut;
      logic hpfOn;
      logic [3:0] kOut;
      logic [4*lane_cfg_pkg::SAMPLE_W-1:0] xPrev;
      logic [4*lane_cfg_pkg::OUT_W-1:0] yPrev;
      logic outValid;
      logic [1:0] outChan;
      logic [15:0] outData;
   } state_s;

   state_s st_reg;
   state_s st_next;

   ////////////////////////////////////////////////////////////////////////////
   // register access and outputs

   logic setup;
   logic wrAccess;
   logic [15:0] wrBytes;
   logic [15:0] strbMask;
   logic mapped;
   logic [15:0] rdVal;
   logic signed [17:0] xs;
   logic signed [17:0] xps;
   logic signed [17:0] yps;
   logic signed [17:0] sum;
   logic signed [35:0] num;
   logic signed [35:0] den;
   logic signed [35:0] quo;
   logic [15:0] yNew;

   always_comb begin
      st_next = st_reg;
      setup = psel && !penable;
      wrAccess = psel && penable && pwrite && st_reg.ready;
      strbMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
      wrBytes = pwdata[15:0];
      mapped = 1'b0;
      rdVal = 16'h0000;
      unique case (paddr)
         lane_cfg_pkg::ADDR_PAT_HPF: begin
            mapped = 1'b1;
            rdVal = st_reg.patHpf;
         end
         lane_cfg_pkg::ADDR_PAT_B: begin
            mapped = 1'b1;
            rdVal = st_reg.patB;
         end
         lane_cfg_pkg::ADDR_MODE: begin
            mapped = 1'b1;
            rdVal = 16'(st_reg.indSel) << lane_cfg_pkg::IND_SEL_POS;
         end
         default: begin
            mapped = 1'b0;
            rdVal = 16'h0000;
         end
      endcase
      // one wait-free access phase: ready rises the cycle after setup
      st_next.ready = setup;
      if (setup) begin
         st_next.rdata = {16'h0000, rdVal};
         st_next.slvErr = !mapped;
      end else if (st_reg.ready) begin
         st_next.rdata = 32'h0000_0000;
         st_next.slvErr = 1'b0;
      end
      if (wrAccess && mapped) begin
         unique case (paddr)
            lane_cfg_pkg::ADDR_PAT_HPF: begin
               st_next.patHpf = ((st_reg.patHpf & ~strbMask) | (wrBytes & strbMask))
                  & lane_cfg_pkg::MASK_PAT_HPF;
            end
            lane_cfg_pkg::ADDR_PAT_B: begin
               st_next.patB = ((st_reg.patB & ~strbMask) | (wrBytes & strbMask))
                  & lane_cfg_pkg::MASK_PAT_B;
            end
            default: begin
               if (pstrb[1]) begin
                  st_next.indSel = wrBytes[lane_cfg_pkg::IND_SEL_POS];
               end
            end
         endcase
      end

      // pseudo-random enables gated by independent select
      st_next.prbsOut = {st_reg.patHpf[lane_cfg_pkg::PRBS16_POS],
                         st_reg.patHpf[lane_cfg_pkg::PRBS15_POS],
                         st_reg.patHpf[lane_cfg_pkg::PRBS14_POS],
                         st_reg.patHpf[lane_cfg_pkg::PRBS13_POS]} & {4{st_reg.indSel}};
      // codes passed through as opaque values with independent select, zero without
      st_next.codeOut = 12'h000;
      if (st_reg.indSel) begin
         st_next.codeOut[2:0] = st_reg.patHpf[lane_cfg_pkg::CODE13_LSB +: 3];
         st_next.codeOut[5:3] = st_reg.patHpf[lane_cfg_pkg::CODE14_LSB +: 3];
         st_next.codeOut[8:6] = st_reg.patB[lane_cfg_pkg::CODE15_LSB +: 3];
         st_next.codeOut[11:9] = st_reg.patB[lane_cfg_pkg::CODE16_LSB +: 3];
      end
      st_next.hpfOn = st_reg.patHpf[lane_cfg_pkg::HPF_EN_POS];
      st_next.kOut = st_reg.patHpf[lane_cfg_pkg::HPF_K_LSB +: 4];

      ////////////////////////////////////////////////////////////////////////
      // per-channel high-pass filter

      xs = {{4{sampleIn[13]}}, sampleIn};
      xps = 18'(signed'(st_reg.xPrev[sampleChan*lane_cfg_pkg::SAMPLE_W +: lane_cfg_pkg::SAMPLE_W]));
      yps = 18'(signed'(st_reg.yPrev[sampleChan*lane_cfg_pkg::OUT_W +: lane_cfg_pkg::OUT_W]));
      // sum, scale by 2^k, divide by 2^k+1, saturate
      sum = xs - xps + yps;
      num = 36'(sum) <<< st_reg.patHpf[lane_cfg_pkg::HPF_K_LSB +: 4];
      den = (36'sh0_0000_0001 <<< st_reg.patHpf[lane_cfg_pkg::HPF_K_LSB +: 4]) + 36'sh0_0000_0001;
      quo = num / den;
      if (quo > lane_cfg_pkg::OUT_MAX) begin
         yNew = 16'h7FFF;
      end else if (quo < lane_cfg_pkg::OUT_MIN) begin
         yNew = 16'h8000;
      end else begin
         yNew = quo[15:0];
      end
      if (!st_reg.patHpf[lane_cfg_pkg::HPF_EN_POS]) begin
         yNew = 16'(xs);
      end
      st_next.outValid = sampleValid;
      if (sampleValid) begin
         st_next.outChan = sampleChan;
         st_next.outData = yNew;
         st_next.xPrev[sampleChan*lane_cfg_pkg::SAMPLE_W +: lane_cfg_pkg::SAMPLE_W] = sampleIn;
         st_next.yPrev[sampleChan*lane_cfg_pkg::OUT_W +: lane_cfg_pkg::OUT_W] = yNew;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.patHpf <= lane_cfg_pkg::RST_PAT_HPF;
         st_reg.patB <= lane_cfg_pkg::RST_PAT_B;
         st_reg.indSel <= lane_cfg_pkg::RST_IND_SEL;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.rdata;
   assign pready = st_reg.ready;
   assign pslverr = st_reg.slvErr;
   assign sampleOutValid = st_reg.outValid;
   assign sampleOutChan = st_reg.outChan;
   assign sampleOut = st_reg.outData;
   assign independentPatternSelect = st_reg.indSel;
   assign pseudoRandomEnLane13 = st_reg.prbsOut[0];
   assign pseudoRandomEnLane14 = st_reg.prbsOut[1];
   assign pseudoRandomEnLane15 = st_reg.prbsOut[2];
   assign pseudoRandomEnLane16 = st_reg.prbsOut[3];
   assign testCodeLane13 = st_reg.codeOut[2:0];
   assign testCodeLane14 = st_reg.codeOut[5:3];
   assign testCodeLane15 = st_reg.codeOut[8:6];
   assign testCodeLane16 = st_reg.codeOut[11:9];
   assign highpassEnableUpperGroup = st_reg.hpfOn;
   assign highpassKUpperGroup = st_reg.kOut;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence apbSetupSeq;
      psel && !penable;
   endsequence

   sequence wrHpfSeq;
      psel && penable && pwrite && pready && pstrb[1:0] == 2'b11
         && paddr == lane_cfg_pkg::ADDR_PAT_HPF;
   endsequence

   sequence wrPatBSeq;
      psel && penable && pwrite && pready && pstrb[1:0] == 2'b11
         && paddr == lane_cfg_pkg::ADDR_PAT_B;
   endsequence

   sequence rdPatBSeq;
      psel && penable && !pwrite && pready && paddr == lane_cfg_pkg::ADDR_PAT_B;
   endsequence

   // no pseudo-random lane without independent select
   prbs_gate_a: assert property (!st_reg.indSel ##1 !st_reg.indSel
      |-> !pseudoRandomEnLane13 && !pseudoRandomEnLane14 && !pseudoRandomEnLane15 && !pseudoRandomEnLane16)
      else $error("pseudo-random lane on without select");

   // lane 13 code follows its field two cycles after a write
   code13_follow_a: assert property (apbSetupSeq ##1 wrHpfSeq ##1 st_reg.indSel
      |=> testCodeLane13 == $past(pwdata[11:9], 2)) else $error("lane 13 code wrong");

   // lane 14 code tracks its field
   code14_follow_a: assert property (st_reg.indSel |=> testCodeLane14 == $past(st_reg.patHpf[8:6]))
      else $error("lane 14 code wrong");

   // lane 15 code tracks its field
   code15_follow_a: assert property (st_reg.indSel |=> testCodeLane15 == $past(st_reg.patB[7:5]))
      else $error("lane 15 code wrong");

   // lane 16 code tracks its field, zero without select
   code16_follow_a: assert property ((st_reg.indSel |=> testCodeLane16 == $past(st_reg.patB[4:2]))
      and (!st_reg.indSel |=> testCodeLane16 == 3'h0)) else $error("lane 16 code wrong");

   hpf_bypass_a: assert property (sampleValid && !st_reg.patHpf[0]
      |=> sampleOutValid && sampleOut == 16'($signed($past(sampleIn)))) else $error("bypass sample altered");

   // filter enable output follows a full write
   hpf_en_out_a: assert property (apbSetupSeq ##1 wrHpfSeq
      |-> ##2 highpassEnableUpperGroup == $past(pwdata[0], 2)) else $error("filter enable wrong");

   // filter parameter output follows the field
   hpf_k_out_a: assert property (apbSetupSeq ##1 wrHpfSeq
      |-> ##2 highpassKUpperGroup == $past(pwdata[4:1], 2)) else $error("filter parameter wrong");

   // zero input on a cleared channel gives zero
   hpf_step_a: assert property (sampleValid && st_reg.patHpf[0] && sampleIn == 14'h0000
      && xps == 18'sh0_0000 && yps == 18'sh0_0000 |=> sampleOut == 16'h0000) else $error("filter output wrong");

   patb_write_a: assert property (apbSetupSeq ##1 wrPatBSeq
      |=> st_reg.patB == ($past(pwdata[15:0]) & lane_cfg_pkg::MASK_PAT_B))
      else $error("second register write lost");
   patb_read_a: assert property (apbSetupSeq ##1 rdPatBSeq
      |-> prdata == {16'h0000, st_reg.patB} && !pslverr) else $error("second register read wrong");

   // first register write with reserved bit held zero
   hpf_write_a: assert property (apbSetupSeq ##1 wrHpfSeq
      |=> st_reg.patHpf == ($past(pwdata[15:0]) & lane_cfg_pkg::MASK_PAT_HPF))
      else $error("first register write lost");

   reset_clear_a: assert property (@(posedge clk) disable iff (1'b0) rst
      |-> st_reg.patHpf == 16'h0000 && st_reg.patB == 16'h0000 && !st_reg.indSel)
      else $error("fields not cleared");

endmodule : lane_pattern_hpf_config

`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sampleValid = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [1:0] sampleChan = 2'h0;
   logic [13:0] sampleIn = 14'h0;
   logic [31:0] prdata;
   logic pready, pslverr, sampleOutValid, independentPatternSelect, highpassEnableUpperGroup;
   logic pseudoRandomEnLane13, pseudoRandomEnLane14, pseudoRandomEnLane15, pseudoRandomEnLane16;
   logic [1:0] sampleOutChan;
   logic [15:0] sampleOut;
   logic [2:0] testCodeLane13, testCodeLane14, testCodeLane15, testCodeLane16;
   logic [3:0] highpassKUpperGroup;
   int numErrors = 0;
   int checksDone = 0;
   int seed = 61152;
   int xPrev [4] = '{default: 0};
   int yPrev [4] = '{default: 0};
   logic [15:0] regA = 16'h0000;
   logic [15:0] regB = 16'h0000;
   logic selV = 1'b0;
   logic [31:0] rd;
   logic err;

   always #25 clk = ~clk;

   lane_pattern_hpf_config dut (
      .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .sampleValid, .sampleChan, .sampleIn, .sampleOutValid, .sampleOutChan, .sampleOut,
      .independentPatternSelect, .pseudoRandomEnLane13, .pseudoRandomEnLane14,
      .pseudoRandomEnLane15, .pseudoRandomEnLane16, .testCodeLane13, .testCodeLane14,
      .testCodeLane15, .testCodeLane16, .highpassEnableUpperGroup, .highpassKUpperGroup
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic printVerdict;
      $display("checks %0d mismatches %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : printVerdict

   task automatic cmpReg(input string nm, input logic [31:0] e, input logic [31:0] g);
      checksDone++;
      if (g !== e) begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : cmpReg

   task automatic cmpSample(input logic [18:0] e, input logic [18:0] g);
      checksDone++;
      if (g !== e) begin
         numErrors++;
         $display("mismatch sample expected %h seen %h", e, g);
      end
   endtask : cmpSample

   function automatic logic [31:0] cfgExp(input logic [15:0] a, input logic [15:0] b, input logic s);
      logic [2:0] m;
      m = {3{s}};
      return {10'h000, s, a[15:12] & {4{s}}, a[11:9] & m, a[8:6] & m, b[7:5] & m, b[4:2] & m, a[0], a[4:1]};
   endfunction : cfgExp

   // filter model, also tracks per-channel history
   function automatic int hpfExp(input int x, input int ch, input logic en, input int k);
      int s;
      int y;
      s = x - xPrev[ch] + yPrev[ch];
      y = en ? (s * (1 << k)) / ((1 << k) + 1) : x;
      if (y > 32767) y = 32767;
      if (y < -32768) y = -32768;
      xPrev[ch] = x;
      yPrev[ch] = y;
      return y;
   endfunction : hpfExp

   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= st;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         numErrors++;
         printVerdict();
      end
   endtask : apb

   task automatic writeReg(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st, input logic ee);
      apb(1'b1, a, d, st);
      cmpReg("write error", {31'h0, ee}, {31'h0, err});
   endtask : writeReg

   task automatic readChk(input logic [11:0] a, input logic [15:0] e, input logic ee);
      apb(1'b0, a, 32'h0, 4'h0);
      cmpReg("read data", {16'h0, e}, rd);
      cmpReg("read error", {31'h0, ee}, {31'h0, err});
   endtask : readChk

   task automatic cfgChk;
      repeat (2) @(posedge clk);
      #1;
      cmpReg("config outputs", cfgExp(regA, regB, selV), {10'h000, independentPatternSelect,
         pseudoRandomEnLane13, pseudoRandomEnLane14, pseudoRandomEnLane15, pseudoRandomEnLane16,
         testCodeLane13, testCodeLane14, testCodeLane15, testCodeLane16,
         highpassEnableUpperGroup, highpassKUpperGroup});
   endtask : cfgChk

   task automatic sendSample(input logic [1:0] ch, input logic [13:0] x, input logic en, input int k);
      int e;
      e = hpfExp(int'($signed(x)), int'(ch), en, k);
      @(posedge clk);
      sampleValid <= 1'b1;
      sampleChan <= ch;
      sampleIn <= x;
      @(posedge clk);
      sampleValid <= 1'b0;
      #1;
      cmpSample({1'b1, ch, e[15:0]}, {sampleOutValid, sampleOutChan, sampleOut});
   endtask : sendSample

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      readChk(lane_cfg_pkg::ADDR_PAT_HPF, 16'h0000, 1'b0);
      readChk(lane_cfg_pkg::ADDR_PAT_B, 16'h0000, 1'b0);
      readChk(lane_cfg_pkg::ADDR_MODE, 16'h0000, 1'b0);
      cfgChk();
      $display("test reset done");
      for (int i = 0; i < 24; i++) begin
         regA = (i < 2) ? 16'hFFD5 : 16'($random(seed)) & lane_cfg_pkg::MASK_PAT_HPF;
         // filter parameter kept within 2 to 10
         if (regA[4:1] < 4'h2 || regA[4:1] > 4'hA) begin
            regA[4:1] = 4'h2 + regA[4:1] % 4'h9;
         end
         regB = (i < 2) ? lane_cfg_pkg::MASK_PAT_B : 16'($random(seed)) & lane_cfg_pkg::MASK_PAT_B;
         selV = (i < 2) ? i[0] : 1'($random(seed));
         writeReg(lane_cfg_pkg::ADDR_PAT_HPF, {16'h0, regA}, 4'hF, 1'b0);
         writeReg(lane_cfg_pkg::ADDR_PAT_B, {16'h0, regB}, 4'hF, 1'b0);
         writeReg(lane_cfg_pkg::ADDR_MODE, {23'h0, selV, 8'h00}, 4'hF, 1'b0);
         cfgChk();
         readChk(lane_cfg_pkg::ADDR_PAT_HPF, regA, 1'b0);
         readChk(lane_cfg_pkg::ADDR_PAT_B, regB, 1'b0);
      end
      writeReg(lane_cfg_pkg::ADDR_PAT_HPF, 32'h0, 4'h2, 1'b0);
      regA = regA & 16'h00FF;
      readChk(lane_cfg_pkg::ADDR_PAT_HPF, regA, 1'b0);
      writeReg(lane_cfg_pkg::ADDR_PAT_B, 32'hFFFF_FFFF, 4'hF, 1'b0);
      regB = lane_cfg_pkg::MASK_PAT_B;
      readChk(lane_cfg_pkg::ADDR_PAT_B, regB, 1'b0);
      writeReg(12'h0F0, 32'h0000_FFFF, 4'hF, 1'b1);
      readChk(12'h0F0, 16'h0000, 1'b1);
      readChk(lane_cfg_pkg::ADDR_PAT_B, regB, 1'b0);
      $display("test registers done");
      // first pass with enable low is the bypass run
      for (int k = 1; k <= 10; k++) begin
         regA = {11'h000, 4'((k > 1) ? k : 2), 1'(k > 1)};
         writeReg(lane_cfg_pkg::ADDR_PAT_HPF, {16'h0, regA}, 4'hF, 1'b0);
         cfgChk();
         for (int j = 0; j < 8; j++) begin
            sendSample((j < 3) ? 2'h3 : 2'($random(seed)),
               (j < 3) ? {j[0], {13{~j[0]}}} : 14'($random(seed)), regA[0], k);
         end
      end
      $display("test filter done");
      // second reset clears fields and filter history
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      regA = 16'h0000;
      regB = 16'h0000;
      selV = 1'b0;
      xPrev = '{default: 0};
      yPrev = '{default: 0};
      readChk(lane_cfg_pkg::ADDR_PAT_HPF, 16'h0000, 1'b0);
      readChk(lane_cfg_pkg::ADDR_PAT_B, 16'h0000, 1'b0);
      readChk(lane_cfg_pkg::ADDR_MODE, 16'h0000, 1'b0);
      cfgChk();
      regA = 16'h0005;
      writeReg(lane_cfg_pkg::ADDR_PAT_HPF, {16'h0, regA}, 4'hF, 1'b0);
      cfgChk();
      sendSample(2'h0, 14'h0000, 1'b1, 2);
      sendSample(2'h0, 14'h1000, 1'b1, 2);
      sendSample(2'h0, 14'h1000, 1'b1, 2);
      sendSample(2'h1, 14'h2000, 1'b1, 2);
      $display("test second reset done");
      printVerdict();
   end
endmodule : tb
`default_nettype wire
